// ---- verilog/otp_params.svh ----
`ifndef OTP_PARAMS_SVH
`define OTP_PARAMS_SVH

// Clock rate in MHz
`define CLK_MHZ 250

// Strobe timing in microseconds
`define PULSE_LOW_US 100
`define PULSE_TOL_US 10
`define PULSE_GAP_MIN_US 10
`define STATION_GAP_US 11

// Cycle counts, derived from the timing above except the fixed station setup count
`define PULSE_MIN_CYC ((`PULSE_LOW_US - `PULSE_TOL_US) * `CLK_MHZ)
`define PULSE_MAX_CYC ((`PULSE_LOW_US + `PULSE_TOL_US) * `CLK_MHZ)
`define PULSE_NOM_CYC (`PULSE_LOW_US * `CLK_MHZ)
`define GAP_MIN_CYC (`PULSE_GAP_MIN_US * `CLK_MHZ)
`define STATION_GAP_CYC (`STATION_GAP_US * `CLK_MHZ)
`define STATION_SETUP_CYC 16'h0010

// Pulses per programming operation
`define PROG_PULSES 3'h5

// Mode pin patterns {p2.7, p2.6, p3.7, p3.6}
`define PAT_PGM_CODE 4'hb
`define PAT_PGM_ENC 4'ha
`define PAT_PGM_LOCK1 4'hf
`define PAT_PGM_LOCK2 4'hc
`define PAT_PGM_LOCK3 4'h5
`define PAT_PGM_SIX 4'h2
`define PAT_SIG 4'h0
`define PAT_VERIFY 4'h3
`define PAT_VERIFY_SIX 4'h1
`define PAT_VERIFY_LOCK 4'h2

// Pin and field positions
`define P2_ENABLE_BIT 7
`define P2_SELECT_BIT 6
`define P2_ADDR_MSB 5
`define ADDR_W 14
`define CODE_BYTES 16384
`define ENC_BYTES 64
`define ENC_IDX_MSB 5
`define LOCK1_IDX 0
`define LOCK2_IDX 1
`define LOCK3_IDX 2
`define OUT_LOCK1_BIT 7
`define OUT_LOCK2_BIT 6
`define OUT_LOCK3_BIT 3
`define OUT_SIX_BIT 4

// Values
`define ERASED_BYTE 8'hff
`define SIG_ADDR_0 14'h0030
`define SIG_ADDR_1 14'h0031
`define SIG_ADDR_VARIANT 14'h0060

`endif

// ---- verilog/otp_pkg.sv ----
`include "otp_params.svh"

package otp_pkg;

  typedef enum logic [3:0] {
    MODE_IDLE,
    MODE_SIG,
    MODE_VERIFY,
    MODE_VERIFY_SIX,
    MODE_VERIFY_LOCK,
    MODE_PGM_CODE,
    MODE_PGM_ENC,
    MODE_PGM_LOCK1,
    MODE_PGM_LOCK2,
    MODE_PGM_LOCK3,
    MODE_PGM_SIX
  } mode_type;

  typedef struct packed {
    logic rst;
    logic program_store_enable;
    logic program_strobe;
    logic program_voltage_enable;
    logic [7:0] p1;
    logic [7:0] p2;
    logic p3_7;
    logic p3_6;
    logic p3_3;
    logic [7:0] p0;
  } pins_type;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'h0,
    DEV_LOW = 2'h1,
    DEV_HIGH = 2'h3,
    DEV_FAULT = 2'h2
  } dev_state_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_LOW = 3'h3,
    ST_HIGH = 3'h2,
    ST_HOLD = 3'h6
  } st_state_type;

  typedef struct packed {
    pins_type sync1;
    pins_type sync2;
    dev_state_type state;
    logic [2:0] pulses;
    logic [15:0] cnt;
    mode_type mode;
    logic [13:0] addr;
    logic [7:0] data;
    logic commit;
    logic [2:0] lock;
    logic six_clock;
    logic error;
    logic [7:0] p0;
    logic p0_oe;
  } dev_regs_type;

  typedef struct packed {
    st_state_type state;
    logic [15:0] cnt;
    logic [2:0] pulses;
    mode_type mode;
    pins_type drive;
    logic p0_oe;
    logic [7:0] p0_sync1;
    logic [7:0] p0_sync2;
    logic ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
  } st_regs_type;

  function automatic logic is_write(mode_type m);
    is_write = (m == MODE_PGM_CODE) || (m == MODE_PGM_ENC) || (m == MODE_PGM_LOCK1) ||
               (m == MODE_PGM_LOCK2) || (m == MODE_PGM_LOCK3) || (m == MODE_PGM_SIX);
  endfunction

  function automatic logic [3:0] mode_pattern(mode_type m);
    case (m)
      MODE_PGM_CODE: mode_pattern = `PAT_PGM_CODE;
      MODE_PGM_ENC: mode_pattern = `PAT_PGM_ENC;
      MODE_PGM_LOCK1: mode_pattern = `PAT_PGM_LOCK1;
      MODE_PGM_LOCK2: mode_pattern = `PAT_PGM_LOCK2;
      MODE_PGM_LOCK3: mode_pattern = `PAT_PGM_LOCK3;
      MODE_PGM_SIX: mode_pattern = `PAT_PGM_SIX;
      MODE_VERIFY: mode_pattern = `PAT_VERIFY;
      MODE_VERIFY_SIX: mode_pattern = `PAT_VERIFY_SIX;
      MODE_VERIFY_LOCK: mode_pattern = `PAT_VERIFY_LOCK;
      default: mode_pattern = `PAT_SIG;
    endcase
  endfunction

endpackage

// ---- verilog/otp_prog_if.sv ----
`timescale 1ns/10ps
`include "otp_params.svh"

interface otp_prog_if;
  otp_pkg::pins_type st_pins;
  logic st_p0_oe;
  logic [7:0] dev_p0;
  logic dev_p0_oe;
  logic [7:0] p0_level;
  otp_pkg::pins_type bus;

  // Port 0 resolution with pull-ups
  assign p0_level = dev_p0_oe ? dev_p0 : (st_p0_oe ? st_pins.p0 : `ERASED_BYTE);

  always_comb
  begin
    bus = st_pins;
    bus.p0 = p0_level;
  end

  modport device (input bus, output dev_p0, output dev_p0_oe);
  modport station (output st_pins, output st_p0_oe, input p0_level);
endinterface

// ---- verilog/otp_device.sv ----
`timescale 1ns/10ps
`include "otp_params.svh"

// Summary of operation
// R1: Station keeps oscillator running during operations
// R2: Address on ports 1/2, data port 0
// R3: Mode levels held steady whole sequence
// R4: Five strobe low pulses per operation
// R5: Low 100us +-10, high at least 10us
// R6: Encryption table written; verify then encrypted
// R7: Any lock bit refuses code/table writes
// R8: Verify drives addressed byte onto port 0
// R9: Encrypted verify is XNOR with table byte
// R10: Encryption table never readable from outside
// R11: Signature bytes at 030, 031, 060
// R12: Six-clock option programmed by its pin pattern
// R13: Option verify on port 0 bit 4
// R14: Lock verify on port 0 bits 7,6,3
// R15: Lock bits programmed by selected pin pattern
// R16: Lock 1 blocks table read, latches access
// R17: Locks 1 and 2 disable verify output
// R18: Lock 3 blocks external execution, RAM
// R19: Table starts all ones, meaning no encryption
// R20: Station uses only defined lock combinations
// R21: Enable input gates write versus read modes
// R22: Verify blocked when locks 1 and 2 set
module otp_device #(
  parameter logic [15:0] PULSE_MIN_CYC = 16'(`PULSE_MIN_CYC),
  parameter logic [15:0] PULSE_MAX_CYC = 16'(`PULSE_MAX_CYC),
  parameter logic [7:0] SIG_BYTE_0 = 8'h5a,
  parameter logic [7:0] SIG_BYTE_1 = 8'ha5,
  parameter logic [7:0] SIG_VARIANT = 8'h3c
)(
  input wire logic clk_i,
  input wire logic rst_b_i,
  otp_prog_if.device link,
  output logic [2:0] lock_bits_o,
  output logic six_clock_mode_o,
  output logic code_table_read_block_o,
  output logic external_access_latch_o,
  output logic external_exec_block_o,
  output logic data_ram_block_o,
  output logic program_error_o
);
  // Signature parameter values are arbitrary

  localparam logic [15:0] GAP_MIN_CYC = 16'(`GAP_MIN_CYC);

  otp_pkg::dev_regs_type r;
  otp_pkg::dev_regs_type n;
  otp_pkg::pins_type pn;
  otp_pkg::mode_type m;
  logic [13:0] a;
  logic [7:0] code_mem [`CODE_BYTES];
  logic [7:0] enc_mem [`ENC_BYTES];
  logic [7:0] enc_byte;

  function automatic otp_pkg::mode_type decode_mode(otp_pkg::pins_type p);
    logic [3:0] pat;
    pat = {p.p2[`P2_ENABLE_BIT], p.p2[`P2_SELECT_BIT], p.p3_7, p.p3_6};
    decode_mode = otp_pkg::MODE_IDLE;
    if (p.rst && !p.program_store_enable)
    begin
      if (p.program_voltage_enable)
      begin
        case (pat) // R21
          `PAT_PGM_CODE: decode_mode = otp_pkg::MODE_PGM_CODE;
          `PAT_PGM_ENC: decode_mode = otp_pkg::MODE_PGM_ENC;
          `PAT_PGM_LOCK1: decode_mode = otp_pkg::MODE_PGM_LOCK1; // R15
          `PAT_PGM_LOCK2: decode_mode = otp_pkg::MODE_PGM_LOCK2; // R15
          `PAT_PGM_LOCK3: decode_mode = otp_pkg::MODE_PGM_LOCK3; // R15
          `PAT_PGM_SIX: decode_mode = p.p3_3 ? otp_pkg::MODE_IDLE : otp_pkg::MODE_PGM_SIX; // R12
          default: decode_mode = otp_pkg::MODE_IDLE;
        endcase
      end
      else if (p.program_strobe)
      begin
        case (pat) // R21
          `PAT_SIG: decode_mode = otp_pkg::MODE_SIG; // R11
          `PAT_VERIFY: decode_mode = otp_pkg::MODE_VERIFY;
          `PAT_VERIFY_SIX: decode_mode = p.p3_3 ? otp_pkg::MODE_VERIFY_SIX : otp_pkg::MODE_IDLE;
          `PAT_VERIFY_LOCK: decode_mode = otp_pkg::MODE_VERIFY_LOCK;
          default: decode_mode = otp_pkg::MODE_IDLE;
        endcase
      end
    end
  endfunction

  assign pn = r.sync2;
  assign m = decode_mode(pn);
  assign a = {pn.p2[`P2_ADDR_MSB:0], pn.p1}; // R2
  assign enc_byte = enc_mem[a[`ENC_IDX_MSB:0]];

  always_comb
  begin
    n = r;
    n.sync1 = link.bus;
    n.sync2 = r.sync1;
    n.commit = 1'h0;
    n.p0 = `ERASED_BYTE;
    n.p0_oe = 1'h0;
    // Read side; no mode ever presents enc_mem directly
    case (m) // R10
      otp_pkg::MODE_VERIFY:
      begin
        n.p0_oe = !(r.lock[`LOCK1_IDX] && r.lock[`LOCK2_IDX]); // R17 R22
        n.p0 = ~(code_mem[a] ^ enc_byte); // R8 R9 R6 R19
      end
      otp_pkg::MODE_SIG:
      begin
        n.p0_oe = 1'h1;
        if (a == `SIG_ADDR_0)
          n.p0 = SIG_BYTE_0; // R11
        else if (a == `SIG_ADDR_1)
          n.p0 = SIG_BYTE_1; // R11
        else if (a == `SIG_ADDR_VARIANT)
          n.p0 = SIG_VARIANT; // R11
      end
      otp_pkg::MODE_VERIFY_SIX:
      begin
        n.p0_oe = 1'h1;
        n.p0[`OUT_SIX_BIT] = !r.six_clock; // R13
      end
      otp_pkg::MODE_VERIFY_LOCK:
      begin
        n.p0_oe = 1'h1;
        n.p0[`OUT_LOCK1_BIT] = !r.lock[`LOCK1_IDX]; // R14
        n.p0[`OUT_LOCK2_BIT] = !r.lock[`LOCK2_IDX]; // R14
        n.p0[`OUT_LOCK3_BIT] = !r.lock[`LOCK3_IDX]; // R14
      end
      default:
      begin
        n.p0_oe = 1'h0;
      end
    endcase
    // Strobe pulse sequencer
    unique case (r.state)
      otp_pkg::DEV_IDLE:
      begin
        n.cnt = '0;
        n.pulses = '0;
        if (otp_pkg::is_write(m) && !pn.program_strobe)
        begin
          n.state = otp_pkg::DEV_LOW;
          n.mode = m;
          n.addr = a;
          n.data = pn.p0;
          n.error = 1'h0;
          n.cnt = 16'h0001;
        end
      end
      otp_pkg::DEV_LOW:
      begin
        if (m != r.mode)
          n.state = otp_pkg::DEV_FAULT; // R3
        else if (pn.program_strobe)
        begin
          n.cnt = 16'h0001;
          if (r.cnt < PULSE_MIN_CYC)
            n.state = otp_pkg::DEV_FAULT; // R5
          else if (r.pulses == `PROG_PULSES - 3'h1)
          begin
            n.state = otp_pkg::DEV_IDLE; // R4
            case (r.mode)
              otp_pkg::MODE_PGM_LOCK1: n.lock[`LOCK1_IDX] = 1'h1; // R15
              otp_pkg::MODE_PGM_LOCK2: n.lock[`LOCK2_IDX] = 1'h1; // R15
              otp_pkg::MODE_PGM_LOCK3: n.lock[`LOCK3_IDX] = 1'h1; // R15
              otp_pkg::MODE_PGM_SIX: n.six_clock = 1'h1; // R12
              otp_pkg::MODE_PGM_CODE: n.commit = (r.lock == '0); // R7 R16
              otp_pkg::MODE_PGM_ENC: n.commit = (r.lock == '0); // R7 R6
              default: n.commit = 1'h0;
            endcase
          end
          else
          begin
            n.pulses = r.pulses + 3'h1;
            n.state = otp_pkg::DEV_HIGH;
          end
        end
        else if (r.cnt > PULSE_MAX_CYC)
          n.state = otp_pkg::DEV_FAULT; // R5
        else
          n.cnt = r.cnt + 16'h0001;
      end
      otp_pkg::DEV_HIGH:
      begin
        if (m != r.mode)
          n.state = otp_pkg::DEV_FAULT; // R3
        else if (!pn.program_strobe)
        begin
          n.cnt = 16'h0001;
          n.state = (r.cnt >= GAP_MIN_CYC) ? otp_pkg::DEV_LOW : otp_pkg::DEV_FAULT; // R5
        end
        else if (r.cnt != '1)
          n.cnt = r.cnt + 16'h0001;
      end
      otp_pkg::DEV_FAULT:
      begin
        n.error = 1'h1;
        if (m != r.mode)
          n.state = otp_pkg::DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r <= '0;
      r.mode <= otp_pkg::MODE_IDLE;
      r.state <= otp_pkg::DEV_IDLE;
      r.p0 <= `ERASED_BYTE;
    end
    else
      r <= n;
  end

  // Encryption table, erased to all ones
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < `ENC_BYTES; i++)
        enc_mem[i] <= `ERASED_BYTE; // R19
    end
    else if (r.commit && r.mode == otp_pkg::MODE_PGM_ENC)
      enc_mem[r.addr[`ENC_IDX_MSB:0]] <= r.data; // R6
  end

  always_ff @(posedge clk_i)
  begin
    if (r.commit && r.mode == otp_pkg::MODE_PGM_CODE)
      code_mem[r.addr] <= r.data; // R2
  end

  assign link.dev_p0 = r.p0;
  assign link.dev_p0_oe = r.p0_oe;
  assign lock_bits_o = r.lock;
  assign six_clock_mode_o = r.six_clock;
  assign code_table_read_block_o = r.lock[`LOCK1_IDX]; // R16
  assign external_access_latch_o = r.lock[`LOCK1_IDX]; // R16
  assign external_exec_block_o = r.lock[`LOCK3_IDX]; // R18
  assign data_ram_block_o = r.lock[`LOCK3_IDX]; // R18
  assign program_error_o = r.error;

endmodule // otp_device

// ---- verilog/otp_station.sv ----
`timescale 1ns/10ps
`include "otp_params.svh"

module otp_station #(
  parameter logic [15:0] PULSE_LOW_CYC = 16'(`PULSE_NOM_CYC)
)(
  input wire logic clk_i,
  input wire logic rst_b_i,
  otp_prog_if.station link,
  input wire logic cmd_valid_i,
  input wire otp_pkg::mode_type cmd_mode_i,
  input wire logic [13:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o
);
  localparam logic [15:0] GAP_CYC = 16'(`STATION_GAP_CYC);

  otp_pkg::st_regs_type r;
  otp_pkg::st_regs_type n;
  logic [3:0] pat;

  assign pat = otp_pkg::mode_pattern(cmd_mode_i);

  always_comb
  begin
    n = r;
    n.p0_sync1 = link.p0_level;
    n.p0_sync2 = r.p0_sync1;
    n.rsp_valid = 1'h0;
    n.cnt = r.cnt + 16'h0001;
    unique case (r.state)
      otp_pkg::ST_IDLE:
      begin
        n.cnt = '0;
        n.pulses = '0;
        if (cmd_valid_i && r.ready)
        begin
          n.ready = 1'h0;
          n.mode = cmd_mode_i;
          n.drive.program_store_enable = 1'h0; // R3
          n.drive.program_voltage_enable = otp_pkg::is_write(cmd_mode_i); // R21
          n.drive.p1 = cmd_addr_i[7:0]; // R2
          n.drive.p2 = {pat[3], pat[2], cmd_addr_i[`ADDR_W-1:8]}; // R2 R15 R20
          n.drive.p3_7 = pat[1];
          n.drive.p3_6 = pat[0];
          n.drive.p3_3 = (cmd_mode_i == otp_pkg::MODE_VERIFY_SIX); // R12
          n.drive.p0 = cmd_data_i; // R2
          n.p0_oe = otp_pkg::is_write(cmd_mode_i);
          n.state = otp_pkg::ST_SETUP;
        end
      end
      otp_pkg::ST_SETUP:
      begin
        if (r.cnt >= `STATION_SETUP_CYC)
        begin
          n.cnt = '0;
          if (otp_pkg::is_write(r.mode))
          begin
            n.drive.program_strobe = 1'h0; // R4
            n.state = otp_pkg::ST_LOW;
          end
          else
            n.state = otp_pkg::ST_HOLD;
        end
      end
      otp_pkg::ST_LOW:
      begin
        if (r.cnt >= PULSE_LOW_CYC - 16'h0001)
        begin
          n.cnt = '0;
          n.drive.program_strobe = 1'h1; // R5
          n.pulses = r.pulses + 3'h1;
          n.state = otp_pkg::ST_HIGH;
        end
      end
      otp_pkg::ST_HIGH:
      begin
        if (r.cnt >= GAP_CYC - 16'h0001)
        begin
          n.cnt = '0;
          if (r.pulses == `PROG_PULSES) // R4
            n.state = otp_pkg::ST_HOLD;
          else
          begin
            n.drive.program_strobe = 1'h0; // R5
            n.state = otp_pkg::ST_LOW;
          end
        end
      end
      otp_pkg::ST_HOLD:
      begin
        if (r.cnt >= `STATION_SETUP_CYC)
        begin
          n.cnt = '0;
          n.rsp_valid = !otp_pkg::is_write(r.mode);
          n.rsp_data = r.p0_sync2;
          n.drive.program_store_enable = 1'h1;
          n.drive.program_voltage_enable = 1'h0;
          n.p0_oe = 1'h0;
          n.ready = 1'h1;
          n.state = otp_pkg::ST_IDLE;
        end
      end
      default:
      begin
        n.state = otp_pkg::ST_IDLE;
        n.ready = 1'h1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) // R1
  begin
    if (!rst_b_i)
    begin
      r <= '0;
      r.state <= otp_pkg::ST_IDLE;
      r.mode <= otp_pkg::MODE_IDLE;
      r.drive.rst <= 1'h1;
      r.drive.program_store_enable <= 1'h1;
      r.drive.program_strobe <= 1'h1;
      r.ready <= 1'h1;
    end
    else
      r <= n;
  end

  assign link.st_pins = r.drive;
  assign link.st_p0_oe = r.p0_oe;
  assign cmd_ready_o = r.ready;
  assign rsp_valid_o = r.rsp_valid;
  assign rsp_data_o = r.rsp_data;

endmodule // otp_station

// ---- tb/otp_link_monitor.sv ----
`timescale 1ns/10ps
module otp_link_monitor #(
  parameter logic [15:0] LOW_CYC = 16'h000a,
  parameter logic [15:0] GAP_CYC = 16'h0abe
)(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire otp_pkg::pins_type st_pins,
  input wire logic st_p0_oe,
  input wire logic [7:0] dev_p0,
  input wire logic dev_p0_oe,
  input wire logic [7:0] p0_level
);
  logic [15:0] low_cnt_r;
  logic [15:0] high_cnt_r;
  logic [2:0] pulse_cnt_r;
  logic strobe;
  logic pve;
  assign strobe = st_pins.program_strobe;
  assign pve = st_pins.program_voltage_enable;

  // Strobe phase lengths and pulses per write
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      low_cnt_r <= 16'h0000;
      high_cnt_r <= 16'h0000;
      pulse_cnt_r <= 3'h0;
    end
    else
    begin
      low_cnt_r <= strobe ? 16'h0000 : low_cnt_r + 16'h0001;
      high_cnt_r <= !strobe ? 16'h0000 : high_cnt_r + {15'h0000, high_cnt_r != 16'hffff};
      if (!pve)
        pulse_cnt_r <= 3'h0;
      else if ($fell(strobe))
        pulse_cnt_r <= pulse_cnt_r + 3'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_write_held;
    pve [*4];
  endsequence
  sequence s_idle_held;
    st_pins.program_store_enable [*4];
  endsequence

  a_low_width: assert property ($rose(strobe) |-> low_cnt_r == LOW_CYC)
    else $error("strobe low width wrong");
  a_gap_width: assert property (($fell(strobe) && pulse_cnt_r != 3'h0) |-> high_cnt_r == GAP_CYC)
    else $error("strobe high gap wrong");
  a_five_pulses: assert property ($fell(pve) |-> pulse_cnt_r == 3'h5)
    else $error("pulse count per write wrong");
  a_mode_pins_held: assert property (!strobe |-> $stable({st_pins.rst,
    st_pins.program_store_enable, pve, st_pins.p2, st_pins.p3_7, st_pins.p3_6, st_pins.p3_3}))
    else $error("mode pins moved during pulse");
  a_addr_data_held: assert property (!strobe |-> $stable({st_pins.p1, st_pins.p0}) && st_p0_oe)
    else $error("address or data moved during pulse");
  a_strobe_write_only: assert property ($fell(strobe) |->
    pve && !st_pins.program_store_enable && st_pins.rst)
    else $error("strobe outside write mode");
  a_write_quiet: assert property (s_write_held |-> !dev_p0_oe)
    else $error("device drives port 0 in write mode");
  a_idle_quiet: assert property (s_idle_held |-> !dev_p0_oe)
    else $error("device drives port 0 outside a mode");
  a_read_strobe_high: assert property (dev_p0_oe |-> strobe && p0_level == dev_p0)
    else $error("device drives port 0 while strobe low");
endmodule // otp_link_monitor

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  // Arbitrary identity values
  localparam logic [7:0] SIG_A = 8'h6e;
  localparam logic [7:0] SIG_B = 8'h91;
  localparam logic [7:0] SIG_C = 8'h27;
  localparam logic [15:0] LOW_CYC = 16'h000a;
  localparam logic [13:0] CODE_ADDR = 14'h0145;
  localparam logic [7:0] CODE_BYTE = 8'h96;
  localparam logic [7:0] KEY_BYTE = 8'h3c;
  localparam int LIMIT = 40000;

  logic clk;
  logic rst_b;
  logic cmd_valid;
  otp_pkg::mode_type cmd_mode;
  logic [13:0] cmd_addr;
  logic [7:0] cmd_data;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic [2:0] lock_bits;
  logic six_clock;
  logic table_block;
  logic access_latch;
  logic exec_block;
  logic ram_block;
  logic prog_error;
  logic [7:0] q;
  int n_fail = 0;
  int n_checks = 0;
  int k;
  logic [13:0] sig_addr [4] = '{14'h0030, 14'h0031, 14'h0060, 14'h0050};
  logic [7:0] sig_exp [4] = '{SIG_A, SIG_B, SIG_C, 8'hff};

  otp_prog_if link_if ();

  otp_station #(.PULSE_LOW_CYC(LOW_CYC)) i_otp_station (
    .clk_i(clk), .rst_b_i(rst_b), .link(link_if),
    .cmd_valid_i(cmd_valid), .cmd_mode_i(cmd_mode), .cmd_addr_i(cmd_addr),
    .cmd_data_i(cmd_data), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data));

  otp_device #(.PULSE_MIN_CYC(16'h0008), .PULSE_MAX_CYC(16'h000c), .SIG_BYTE_0(SIG_A),
    .SIG_BYTE_1(SIG_B), .SIG_VARIANT(SIG_C)) i_otp_device (
    .clk_i(clk), .rst_b_i(rst_b), .link(link_if), .lock_bits_o(lock_bits),
    .six_clock_mode_o(six_clock), .code_table_read_block_o(table_block),
    .external_access_latch_o(access_latch), .external_exec_block_o(exec_block),
    .data_ram_block_o(ram_block), .program_error_o(prog_error));

  otp_link_monitor #(.LOW_CYC(LOW_CYC), .GAP_CYC(16'h0abe)) i_otp_link_monitor (
    .clk_i(clk), .rst_b_i(rst_b), .st_pins(link_if.st_pins), .st_p0_oe(link_if.st_p0_oe),
    .dev_p0(link_if.dev_p0), .dev_p0_oe(link_if.dev_p0_oe), .p0_level(link_if.p0_level));

  always #2 clk = ~clk;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One station command, waits for ready to return
  task automatic op(input otp_pkg::mode_type m, input logic [13:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int i;
    r = 8'h00;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_mode <= m;
    cmd_addr <= a;
    cmd_data <= d;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (cmd_ready !== 1'b1 && i < LIMIT);
    cmd_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      i++;
      if (rsp_valid === 1'b1)
        r = rsp_data;
    end
    while (cmd_ready !== 1'b1 && i < LIMIT);
    if (i >= LIMIT)
    begin
      n_fail++;
      $display("Error command timeout");
      wrap_up();
    end
  endtask

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_mode = otp_pkg::MODE_IDLE;
    cmd_addr = 14'h0000;
    cmd_data = 8'h00;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("lock_bits", {5'h00, lock_bits}, 8'h00);
    check("six_clock", {7'h00, six_clock}, 8'h00);
    op(otp_pkg::MODE_VERIFY_SIX, 14'h0000, 8'h00, q);
    check("verify_six", q, 8'hff);
    op(otp_pkg::MODE_VERIFY_LOCK, 14'h0000, 8'h00, q);
    check("verify_lock", q, 8'hff);
    for (k = 0; k < 4; k++)
    begin
      op(otp_pkg::MODE_SIG, sig_addr[k], 8'h00, q);
      check("signature", q, sig_exp[k]);
    end
    op(otp_pkg::MODE_PGM_CODE, CODE_ADDR, CODE_BYTE, q);
    op(otp_pkg::MODE_VERIFY, CODE_ADDR, 8'h00, q);
    check("verify_plain", q, CODE_BYTE);
    op(otp_pkg::MODE_PGM_ENC, 14'h0005, KEY_BYTE, q);
    op(otp_pkg::MODE_VERIFY, CODE_ADDR, 8'h00, q);
    check("verify_encrypted", q, ~(CODE_BYTE ^ KEY_BYTE));
    check("program_error", {7'h00, prog_error}, 8'h00);
    op(otp_pkg::MODE_PGM_SIX, 14'h0000, 8'h00, q);
    check("six_clock_set", {7'h00, six_clock}, 8'h01);
    op(otp_pkg::MODE_VERIFY_SIX, 14'h0000, 8'h00, q);
    check("verify_six_set", q, 8'hef);
    op(otp_pkg::MODE_PGM_LOCK1, 14'h0000, 8'h00, q);
    check("lock_bits_1", {5'h00, lock_bits}, 8'h01);
    check("lock1_flags", {4'h0, table_block, access_latch, exec_block, ram_block}, 8'h0c);
    op(otp_pkg::MODE_VERIFY_LOCK, 14'h0000, 8'h00, q);
    check("verify_lock_1", q, 8'h7f);
    op(otp_pkg::MODE_PGM_CODE, CODE_ADDR, 8'h00, q);
    op(otp_pkg::MODE_VERIFY, CODE_ADDR, 8'h00, q);
    check("refused_write", q, ~(CODE_BYTE ^ KEY_BYTE));
    op(otp_pkg::MODE_PGM_LOCK2, 14'h0000, 8'h00, q);
    op(otp_pkg::MODE_VERIFY, CODE_ADDR, 8'h00, q);
    check("verify_blocked", q, 8'hff);
    op(otp_pkg::MODE_PGM_LOCK3, 14'h0000, 8'h00, q);
    check("lock_bits_3", {5'h00, lock_bits}, 8'h07);
    check("lock3_flags", {4'h0, table_block, access_latch, exec_block, ram_block}, 8'h0f);
    op(otp_pkg::MODE_VERIFY_LOCK, 14'h0000, 8'h00, q);
    check("verify_lock_3", q, 8'h37);
    check("program_error_end", {7'h00, prog_error}, 8'h00);
    wrap_up();
  end
endmodule // tb_top
